// ### design/spipc_core.sv
// Purpose: command strobes, packet length, command count and slave status word of the SPI block
// Assumes: FIFOs, data path and the master engine sit outside and use the strobes below
// Notes: all outputs registered; link pins sampled through two flops in the shifter
// Functional notes
// [RL1] writing send-early clears transmit-not-ready in slave mode at once
// [RL2] send-early stays set until the first data frame has shifted out
// [RL3] stall bit holds off master transmission until a packet is queued
// [RL4] stall bit clears itself once a full packet is queued
// [RL5] frame-counter clear zeroes the frame counter and reads as zero
// [RL6] frame counter also zeroed when disabled or the limit register written
// [RL7] transmit flush bit empties the transmit FIFO and reads as zero
// [RL8] receive flush bit empties the receive FIFO and reads as zero
// [RL9] auto-discard drops received frames until limit reached or, in slave mode, select ends
// [RL10] auto-pad pushes zero frames up to the limit, clears when the frame count reaches the limit
// [RL11] software queues command bytes, sets auto-pad, then drains receive FIFO
// [RL12] software keeps packet length within the FIFO depth
// [RL13] command interrupt once command-count frames arrived since select active
// [RL14] command counter restarts whenever slave select goes inactive
// [RL15] in TI framing any gap between frames restarts the command count
// [RL16] user status bits are written by software and sent to the master
// [RL17] transmit-not-ready reads 0 only when a full packet is queued or send-early is set
// [RL18] receive-not-ready reads 1 while the receive buffer is not empty
// [RL19] status word bits above the user bits come from queued transmit data
// [RL20] status-first option sends the status byte as first slave frame
// [RL21] drop-first option discards the first received frame of a transfer
// [RL22] active frame counter pauses the transfer at its limit and flags it
// [RL23] sent status keeps the register bit positions for busy and user bits
//
// The register addresses and the address-and-strobe port were chosen for this implementation.
`timescale 1ns/1ps
`include "spipc_map.svh"
module spipc_core
    import spipc_pkg::*;
(
    input wire logic sys_clk,
    input wire logic rst_n,
    input wire logic [`SPIPC_ADDR_W-1:0] regAddr,
    input wire logic [31:0] regWrData,
    input wire logic regWrEn,
    input wire logic regRdEn,
    output logic [31:0] regRdData,
    input wire logic spiClk,
    input wire logic ssN,
    input wire logic mosi,
    output logic misoOut,
    output logic misoOeN,
    input wire spipc_byte_t txLevel,
    input wire logic rxEmpty,
    input wire spipc_byte_t txHead,
    output logic txFlush,
    output logic rxFlush,
    output logic txPop,
    output logic zeroPush,
    output logic rxPush,
    output spipc_byte_t rxData,
    output logic masterGo,
    output logic transferPause,
    output logic limitIrq,
    output logic cmdIrq
);
    logic sendEarly_ff, stall_ff, autoDiscard_ff, autoPad_ff, transmit_not_ready_ff, receive_not_ready_ff;
    spipc_byte_t pktLen_ff, command_frame_count_ff, frame_count_limit_ff, cmdCnt_ff;
    logic [31:2] statusHi_ff;
    spipc_opt_s opt_ff;
    spipc_pad_e padState_ff;
    logic ssPrev_ff;
    spipc_evt_s evt;
    logic loadPop, ssActive, shMiso, shMisoOeN;
    logic cmdWr, optWr, ssEnd, packetReady, limitHit, padMore;
    spipc_byte_t statusByte;

    function automatic logic atCount(input spipc_byte_t cnt, input spipc_byte_t lim);
        atCount = (lim != 8'h00) && (cnt == lim);
    endfunction

    function automatic logic sumBelow(input spipc_byte_t a, input spipc_byte_t b,
                                      input spipc_byte_t lim);
        sumBelow = ({1'b0, a} + {1'b0, b}) < {1'b0, lim};
    endfunction

    assign cmdWr = regWrEn && (regAddr == `SPIPC_OFS_COMMAND);
    assign optWr = regWrEn && (regAddr == `SPIPC_OFS_OPTIONS);
    assign ssEnd = ssPrev_ff & ~ssActive;
    assign packetReady = (pktLen_ff != 8'h00) && (txLevel >= pktLen_ff);
    assign limitHit = ~opt_ff.cntOff & atCount(frame_count_limit_ff, opt_ff.limit);
    assign padMore = sumBelow(txLevel, frame_count_limit_ff, opt_ff.limit);
    // upper bits follow the queued data byte, low bits are the status fields
    assign statusByte = {txHead[7:4], statusHi_ff[3:2], transmit_not_ready_ff, receive_not_ready_ff}; // RL19 RL23 RL16

    spipc_shifter u_shifter (
        .sys_clk(sys_clk),
        .rst_n(rst_n),
        .spiClk(spiClk),
        .ssN(ssN),
        .mosi(mosi),
        .tiMode(opt_ff.tiMode),
        .useStatus(opt_ff.statusFirst & ~opt_ff.master), // RL20
        .statusByte(statusByte),
        .txByte(txHead),
        .evt(evt),
        .loadPop(loadPop),
        .ssActive(ssActive),
        .misoOut(shMiso),
        .misoOeN(shMisoOeN)
    );

    // pins pass straight from the shifter flops
    assign misoOut = shMiso;
    assign misoOeN = shMisoOeN;

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            pktLen_ff <= `SPIPC_RST_BYTE;
            command_frame_count_ff <= `SPIPC_RST_BYTE;
            statusHi_ff <= 30'h0;
            opt_ff <= '0;
        end else if (regWrEn) begin
            case (regAddr)
                `SPIPC_OFS_PACKET: pktLen_ff <= regWrData[7:0];
                `SPIPC_OFS_COMMAND_FRAME_COUNT: command_frame_count_ff <= regWrData[7:0];
                `SPIPC_OFS_STATUS: statusHi_ff <= regWrData[31:2]; // RL16
                `SPIPC_OFS_OPTIONS: begin
                    opt_ff.enable <= regWrData[`SPIPC_OPT_ENABLE];
                    opt_ff.master <= regWrData[`SPIPC_OPT_MASTER];
                    opt_ff.tiMode <= regWrData[`SPIPC_OPT_TI];
                    opt_ff.statusFirst <= regWrData[`SPIPC_OPT_STATUS_FIRST];
                    opt_ff.dropFirst <= regWrData[`SPIPC_OPT_DROP_FIRST];
                    opt_ff.cntOff <= regWrData[`SPIPC_OPT_CNT_OFF];
                    opt_ff.limit <= regWrData[`SPIPC_OPT_LIMIT_HI:`SPIPC_OPT_LIMIT_LO];
                end
                default: ;
            endcase
        end
    end

    // command bits: a software set wins over the hardware clear in the same cycle
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            sendEarly_ff <= 1'b0;
            stall_ff <= 1'b0;
            autoDiscard_ff <= 1'b0;
            autoPad_ff <= 1'b0;
        end else begin
            if (cmdWr && regWrData[`SPIPC_CMD_SEND_EARLY]) begin
                sendEarly_ff <= 1'b1;
            end else if (evt.frameDone) begin
                sendEarly_ff <= 1'b0; // RL2
            end
            if (cmdWr && regWrData[`SPIPC_CMD_STALL]) begin
                stall_ff <= 1'b1;
            end else if (packetReady) begin
                stall_ff <= 1'b0; // RL4
            end
            if (cmdWr && regWrData[`SPIPC_CMD_DISCARD]) begin
                autoDiscard_ff <= 1'b1;
            end else if (cmdWr || limitHit || (ssEnd && !opt_ff.master)) begin
                autoDiscard_ff <= 1'b0; // RL9
            end
            if (cmdWr && regWrData[`SPIPC_CMD_ZERO_PAD]) begin
                autoPad_ff <= 1'b1;
            end else if (cmdWr || atCount(frame_count_limit_ff, opt_ff.limit)) begin
                autoPad_ff <= 1'b0; // RL10
            end
        end
    end

    // hardware status bits
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            transmit_not_ready_ff <= 1'b0;
            receive_not_ready_ff <= 1'b0;
        end else begin
            if (cmdWr && regWrData[`SPIPC_CMD_SEND_EARLY]) begin
                transmit_not_ready_ff <= 1'b0; // RL1
            end else if (sendEarly_ff) begin
                transmit_not_ready_ff <= 1'b0;
            end else begin
                transmit_not_ready_ff <= ~packetReady; // RL17
            end
            receive_not_ready_ff <= ~rxEmpty; // RL18
        end
    end

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            frame_count_limit_ff <= `SPIPC_RST_BYTE;
            limitIrq <= 1'b0;
            transferPause <= 1'b0;
        end else begin
            if ((cmdWr && regWrData[`SPIPC_CMD_CNT_CLEAR]) || !opt_ff.enable || optWr) begin
                frame_count_limit_ff <= `SPIPC_RST_BYTE; // RL5 RL6
            end else if (evt.frameDone && frame_count_limit_ff != 8'hff) begin
                frame_count_limit_ff <= frame_count_limit_ff + 8'h01;
            end
            limitIrq <= evt.frameDone & ~opt_ff.cntOff &
                        atCount(frame_count_limit_ff + 8'h01, opt_ff.limit); // RL22
            transferPause <= limitHit; // RL22
        end
    end

    // command counter runs per select window, ti gaps restart it
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            cmdCnt_ff <= `SPIPC_RST_BYTE;
            cmdIrq <= 1'b0;
            ssPrev_ff <= 1'b0;
        end else begin
            ssPrev_ff <= ssActive;
            cmdIrq <= evt.frameDone & atCount(cmdCnt_ff + 8'h01, command_frame_count_ff); // RL13
            if (evt.frameDone) begin
                cmdCnt_ff <= cmdCnt_ff + 8'h01;
            end else if (!ssActive || evt.gap) begin
                cmdCnt_ff <= `SPIPC_RST_BYTE; // RL14 RL15
            end
        end
    end

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            rxPush <= 1'b0;
            rxData <= `SPIPC_RST_BYTE;
            txPop <= 1'b0;
            txFlush <= 1'b0;
            rxFlush <= 1'b0;
            masterGo <= 1'b0;
        end else begin
            rxPush <= evt.frameDone & opt_ff.enable & ~autoDiscard_ff &
                      ~(opt_ff.dropFirst & evt.firstFrame); // RL9 RL21
            rxData <= evt.rxByte;
            txPop <= loadPop;
            txFlush <= cmdWr & regWrData[`SPIPC_CMD_TX_FLUSH]; // RL7
            rxFlush <= cmdWr & regWrData[`SPIPC_CMD_RX_FLUSH]; // RL8
            masterGo <= opt_ff.enable & opt_ff.master & ~stall_ff & ~limitHit; // RL3 RL22
        end
    end

    // one zero push per two cycles so the fifo level has caught up
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            padState_ff <= PAD_IDLE;
            zeroPush <= 1'b0;
        end else begin
            zeroPush <= 1'b0;
            case (padState_ff)
                PAD_IDLE: begin
                    if (autoPad_ff && padMore) begin
                        zeroPush <= 1'b1; // RL10
                        padState_ff <= PAD_WAIT;
                    end
                end
                PAD_WAIT: padState_ff <= PAD_IDLE;
                default: padState_ff <= PAD_IDLE;
            endcase
        end
    end

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            regRdData <= `SPIPC_RST_WORD;
        end else if (regRdEn) begin
            case (regAddr)
                `SPIPC_OFS_COMMAND: regRdData <= {25'h0, sendEarly_ff, stall_ff, 3'h0,
                                                  autoDiscard_ff, autoPad_ff}; // RL5 RL7 RL8
                `SPIPC_OFS_PACKET: regRdData <= {24'h0, pktLen_ff};
                `SPIPC_OFS_COMMAND_FRAME_COUNT: regRdData <= {24'h0, command_frame_count_ff};
                `SPIPC_OFS_STATUS: regRdData <= {statusHi_ff, transmit_not_ready_ff, receive_not_ready_ff};
                `SPIPC_OFS_OPTIONS: regRdData <= {16'h0, opt_ff.limit, 2'h0, opt_ff.cntOff,
                                                  opt_ff.dropFirst, opt_ff.statusFirst,
                                                  opt_ff.tiMode, opt_ff.master, opt_ff.enable};
                default: regRdData <= `SPIPC_RST_WORD;
            endcase
        end else begin
            regRdData <= `SPIPC_RST_WORD;
        end
    end

    early_clears_busy_a: assert property (@(posedge sys_clk) disable iff (!rst_n) // RL1
        cmdWr && regWrData[`SPIPC_CMD_SEND_EARLY] |=> !transmit_not_ready_ff ##1 !transmit_not_ready_ff)
        else $error("send early did not clear transmit busy");
    early_self_clear_a: assert property (@(posedge sys_clk) disable iff (!rst_n) // RL2
        sendEarly_ff && evt.frameDone && !cmdWr |=> !sendEarly_ff)
        else $error("send early not cleared after first frame");
    stall_blocks_go_a: assert property (@(posedge sys_clk) disable iff (!rst_n) // RL3
        stall_ff |=> !masterGo)
        else $error("master allowed to send while stalled");
    stall_release_a: assert property (@(posedge sys_clk) disable iff (!rst_n) // RL4
        stall_ff && packetReady && !cmdWr |=> !stall_ff)
        else $error("stall bit did not clear on packet ready");
    count_clear_a: assert property (@(posedge sys_clk) disable iff (!rst_n) // RL5
        cmdWr && regWrData[`SPIPC_CMD_CNT_CLEAR] |=> frame_count_limit_ff == 8'h00)
        else $error("frame counter not cleared");
    count_disable_a: assert property (@(posedge sys_clk) disable iff (!rst_n) // RL6
        !opt_ff.enable || optWr |=> frame_count_limit_ff == 8'h00)
        else $error("frame counter not zero while disabled");
    flush_pulses_a: assert property (@(posedge sys_clk) disable iff (!rst_n) // RL7
        cmdWr && regWrData[`SPIPC_CMD_TX_FLUSH] |=> txFlush ##1
        (!txFlush || $past(cmdWr && regWrData[`SPIPC_CMD_TX_FLUSH])))
        else $error("transmit flush not a single pulse");
    strobe_reads_zero_a: assert property (@(posedge sys_clk) disable iff (!rst_n) // RL8
        regRdEn && regAddr == `SPIPC_OFS_COMMAND |=> regRdData[4:2] == 3'h0)
        else $error("self clearing command bits read nonzero");
    discard_drops_a: assert property (@(posedge sys_clk) disable iff (!rst_n) // RL9
        autoDiscard_ff && evt.frameDone |=> !rxPush)
        else $error("frame pushed while discarding");
    command_irq_a: assert property (@(posedge sys_clk) disable iff (!rst_n) // RL13
        evt.frameDone && command_frame_count_ff != 8'h00 && cmdCnt_ff + 8'h01 == command_frame_count_ff |=> cmdIrq)
        else $error("command interrupt missed");
    select_restart_a: assert property (@(posedge sys_clk) disable iff (!rst_n) // RL14
        !ssActive && !evt.frameDone |=> cmdCnt_ff == 8'h00)
        else $error("command counter kept across select release");
    limit_pause_a: assert property (@(posedge sys_clk) disable iff (!rst_n) // RL22
        limitHit |=> transferPause && !masterGo)
        else $error("transfer not paused at frame limit");
endmodule

// ### design/spipc_map.svh
// Purpose: offsets, field positions, reset values and widths of the packet command block
// Assumes: word-aligned byte addresses on the plain register port
// Notes: definitions only
`ifndef SPIPC_MAP_SVH
`define SPIPC_MAP_SVH

`define SPIPC_ADDR_W 8
`define SPIPC_OFS_COMMAND 8'h00
`define SPIPC_OFS_PACKET 8'h04
`define SPIPC_OFS_COMMAND_FRAME_COUNT 8'h08
`define SPIPC_OFS_STATUS 8'h0c
`define SPIPC_OFS_OPTIONS 8'h10

// command strobe bits
`define SPIPC_CMD_SEND_EARLY 6
`define SPIPC_CMD_STALL 5
`define SPIPC_CMD_CNT_CLEAR 4
`define SPIPC_CMD_TX_FLUSH 3
`define SPIPC_CMD_RX_FLUSH 2
`define SPIPC_CMD_DISCARD 1
`define SPIPC_CMD_ZERO_PAD 0

// slave status word bits
`define SPIPC_ST_USER_HI 3
`define SPIPC_ST_USER_LO 2
`define SPIPC_ST_TX_BUSY 1
`define SPIPC_ST_RX_BUSY 0

// options register bits
`define SPIPC_OPT_ENABLE 0
`define SPIPC_OPT_MASTER 1
`define SPIPC_OPT_TI 2
`define SPIPC_OPT_STATUS_FIRST 3
`define SPIPC_OPT_DROP_FIRST 4
`define SPIPC_OPT_CNT_OFF 5
`define SPIPC_OPT_LIMIT_HI 15
`define SPIPC_OPT_LIMIT_LO 8

`define SPIPC_RST_BYTE 8'h00
`define SPIPC_RST_WORD 32'h00000000
`define SPIPC_FRAME_BITS 3'h7

`endif

// ### design/spipc_pkg.sv
// Purpose: types shared by the packet command block and its shifter
// Assumes: 8-bit frames
// Notes: constants live in spipc_map.svh
package spipc_pkg;
    typedef logic [7:0] spipc_byte_t;

    typedef struct packed {
        logic frameDone;
        logic firstFrame;
        logic gap;
        spipc_byte_t rxByte;
    } spipc_evt_s;

    typedef struct packed {
        logic enable;
        logic master;
        logic tiMode;
        logic statusFirst;
        logic dropFirst;
        logic cntOff;
        spipc_byte_t limit;
    } spipc_opt_s;

    typedef enum logic [0:0] {
        PAD_IDLE,
        PAD_WAIT
    } spipc_pad_e;
endpackage

// ### design/spipc_shifter.sv
// Purpose: serial frame shifter for the slave link, mode 0 and TI framing
// Assumes: link clock far slower than sys_clk, sampled through two flops
// Notes: first frame of a transfer may carry the status byte instead of FIFO data
`timescale 1ns/1ps
`include "spipc_map.svh"
module spipc_shifter
    import spipc_pkg::*;
(
    input wire logic sys_clk,
    input wire logic rst_n,
    input wire logic spiClk,
    input wire logic ssN,
    input wire logic mosi,
    input wire logic tiMode,
    input wire logic useStatus,
    input wire spipc_byte_t statusByte,
    input wire spipc_byte_t txByte,
    output spipc_evt_s evt,
    output logic loadPop,
    output logic ssActive,
    output logic misoOut,
    output logic misoOeN
);
    logic sclkS1_ff, sclkS2_ff, sclkS3_ff;
    logic ssS1_ff, ssS2_ff, ssS3_ff;
    logic mosiS1_ff, mosiS2_ff;
    logic [2:0] bitCnt_ff;
    logic busy_ff;
    logic firstPend_ff;
    spipc_byte_t rxSh_ff, txSh_ff;
    logic rise, fall, ssFall, tiStart, doneNow, loadNow, loadFirst;
    spipc_byte_t loadVal;

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            sclkS1_ff <= 1'b0;
            sclkS2_ff <= 1'b0;
            sclkS3_ff <= 1'b0;
            ssS1_ff <= 1'b1;
            ssS2_ff <= 1'b1;
            ssS3_ff <= 1'b1;
            mosiS1_ff <= 1'b0;
            mosiS2_ff <= 1'b0;
        end else begin
            sclkS1_ff <= spiClk;
            sclkS2_ff <= sclkS1_ff;
            sclkS3_ff <= sclkS2_ff;
            ssS1_ff <= ssN;
            ssS2_ff <= ssS1_ff;
            ssS3_ff <= ssS2_ff;
            mosiS1_ff <= mosi;
            mosiS2_ff <= mosiS1_ff;
        end
    end

    assign rise = sclkS2_ff & ~sclkS3_ff;
    assign fall = ~sclkS2_ff & sclkS3_ff;
    assign ssFall = ~tiMode & ~ssS2_ff & ssS3_ff;
    // ti: sync high on an edge with no frame running, or during the last bit
    assign tiStart = tiMode & rise & ssS2_ff & (~busy_ff | (bitCnt_ff == `SPIPC_FRAME_BITS));
    assign doneNow = rise & (tiMode ? busy_ff : ~ssS2_ff) & (bitCnt_ff == `SPIPC_FRAME_BITS);
    assign loadNow = ssFall | tiStart | (doneNow & ~tiMode);
    assign loadFirst = ssFall | (tiStart & ~busy_ff);
    assign loadVal = (loadFirst && useStatus) ? statusByte : txByte;

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            bitCnt_ff <= 3'h0;
            busy_ff <= 1'b0;
            rxSh_ff <= `SPIPC_RST_BYTE;
            evt <= '0;
            firstPend_ff <= 1'b0;
        end else begin
            evt.frameDone <= doneNow;
            evt.firstFrame <= doneNow & firstPend_ff;
            evt.gap <= tiMode & rise & ~busy_ff & ~ssS2_ff;
            if (doneNow) begin
                evt.rxByte <= {rxSh_ff[6:0], mosiS2_ff};
            end
            if (loadFirst) begin
                firstPend_ff <= 1'b1;
            end else if (doneNow) begin
                firstPend_ff <= 1'b0;
            end
            if (!tiMode && ssS2_ff) begin
                bitCnt_ff <= 3'h0;
                busy_ff <= 1'b0;
            end else if (tiStart) begin
                bitCnt_ff <= 3'h0;
                busy_ff <= 1'b1;
            end else if (rise && (busy_ff || !tiMode)) begin
                rxSh_ff <= {rxSh_ff[6:0], mosiS2_ff};
                bitCnt_ff <= bitCnt_ff + 3'h1;
                if (doneNow) begin
                    busy_ff <= ~tiMode;
                end
            end
        end
    end

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            txSh_ff <= `SPIPC_RST_BYTE;
            misoOut <= 1'b0;
            loadPop <= 1'b0;
            ssActive <= 1'b0;
            misoOeN <= 1'b1;
        end else begin
            loadPop <= loadNow & ~(loadFirst & useStatus);
            ssActive <= tiMode ? (busy_ff | tiStart) : ~ssS2_ff;
            misoOeN <= tiMode ? ~(busy_ff | tiStart) : ssS2_ff;
            if (loadNow) begin
                misoOut <= loadVal[7];
                txSh_ff <= {loadVal[6:0], 1'b0};
            end else if (fall) begin
                misoOut <= txSh_ff[7];
                txSh_ff <= {txSh_ff[6:0], 1'b0};
            end
        end
    end
endmodule

// ### verification/spipc_link_model.sv
// Purpose: mode 0 link master facing the slave side of the packet command block
// Assumes: link clock idles low between frames, 160 ns period
// Notes: a released miso line reads as a changing value, never as the last bit
`timescale 1ns/1ps
module spipc_link_model
    import spipc_pkg::*;
(
    output logic spiClk,
    output logic ssN,
    output logic mosi,
    input wire logic misoOut,
    input wire logic misoOeN
);
    initial begin
        spiClk = 1'b0;
        ssN = 1'b1;
        mosi = 1'b0;
    end
    // half a link period after each select change; with the frame's own half period, a full period of setup before the first edge
    task automatic sel(input logic lvl);
        ssN = lvl;
        #80;
    endtask
    task automatic frame(input spipc_byte_t txb, output spipc_byte_t rxb);
        for (int i = 7; i >= 0; i--) begin
            mosi = txb[i];
            #80 spiClk = 1'b1;
            rxb[i] = misoOeN ? ~mosi : misoOut;
            #80 spiClk = 1'b0;
        end
    endtask
endmodule

// ### verification/tb.sv
// Purpose: self-checking bench of the packet command block
// Assumes: slave link driven by spipc_link_model, FIFO side driven by the bench
// Notes: register reads sampled one step after the edge that answers
`timescale 1ns/1ps
`include "spipc_map.svh"
module tb;
    import spipc_pkg::*;
    logic sys_clk, rst_n, regWrEn, regRdEn, rxEmpty;
    logic [`SPIPC_ADDR_W-1:0] regAddr;
    logic [31:0] regWrData, regRdData;
    spipc_byte_t txLevel, txHead, rxData, lastRx, got;
    logic spiClk, ssN, mosi, misoOut, misoOeN, txFlush, rxFlush, txPop, zeroPush, rxPush;
    logic masterGo, transferPause, limitIrq, cmdIrq;
    int n_errors, comparisons, nPush, nCmd, nTxf, nRxf, nPop, nLim;
    spipc_core spipc_core_inst (.sys_clk, .rst_n, .regAddr, .regWrData, .regWrEn, .regRdEn,
        .regRdData, .spiClk, .ssN, .mosi, .misoOut, .misoOeN, .txLevel, .rxEmpty, .txHead,
        .txFlush, .rxFlush, .txPop, .zeroPush, .rxPush, .rxData, .masterGo, .transferPause,
        .limitIrq, .cmdIrq);
    spipc_link_model spipc_link_model_inst (.spiClk, .ssN, .mosi, .misoOut, .misoOeN);
    initial begin
        sys_clk = 1'b0;
        forever #5 sys_clk = ~sys_clk;
    end
    always @(posedge sys_clk) begin
        if (rxPush === 1'b1) begin
            nPush++;
            lastRx = rxData;
        end
        if (cmdIrq === 1'b1) nCmd++;
        if (txFlush === 1'b1) nTxf++;
        if (rxFlush === 1'b1) nRxf++;
        if (txPop === 1'b1) nPop++;
        if (limitIrq === 1'b1) nLim++;
    end
    task automatic tally_and_finish();
        if (n_errors == 0 && comparisons > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            n_errors++;
            $display("[FAIL] t=%0t seen=%h expected=%h", $time, seen, exp);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge sys_clk);
        regAddr <= a;
        regWrData <= d;
        regWrEn <= 1'b1;
        @(posedge sys_clk);
        regWrEn <= 1'b0;
    endtask
    task automatic rdc(input logic [7:0] a, input logic [31:0] exp);
        @(posedge sys_clk);
        regAddr <= a;
        regRdEn <= 1'b1;
        @(posedge sys_clk);
        regRdEn <= 1'b0;
        #1 chk(regRdData, exp);
    endtask
    // one select window holding one frame, miso byte left in got
    task automatic window(input spipc_byte_t b);
        spipc_link_model_inst.sel(1'b0);
        spipc_link_model_inst.frame(b, got);
        spipc_link_model_inst.sel(1'b1);
    endtask
    task automatic t_regs();
        rdc(8'h04, 0);
        rdc(8'h08, 0);
        @(posedge sys_clk);
        regAddr <= 8'h0c;
        regRdEn <= 1'b1;
        @(posedge sys_clk);
        regRdEn <= 1'b0;
        #1 chk(regRdData & 32'hfffffffc, 0);
        wr(8'h20, 32'hffffffff);
        rdc(8'h20, 0);
        wr(8'h04, 3);
        rdc(8'h04, 3);
        wr(8'h08, 1);
        rdc(8'h08, 1);
        wr(8'h0c, 32'h9);
        rdc(8'h0c, 32'ha);
        txLevel <= 8'h03;
        rdc(8'h0c, 32'h8);
        rxEmpty <= 1'b0;
        rdc(8'h0c, 32'h9);
        txLevel <= 8'h00;
        rxEmpty <= 1'b1;
    endtask
    task automatic t_flush();
        wr(8'h00, 32'h1c);
        rdc(8'h00, 0);
        chk(nTxf, 1);
        chk(nRxf, 1);
    endtask
    task automatic t_early();
        wr(8'h10, 32'h01);
        wr(8'h00, 32'h40);
        rdc(8'h0c, 32'h8);
        rdc(8'h00, 32'h40);
        txHead <= 8'h3c;
        for (int k = 0; k < 2; k++) begin
            window(8'ha5 ^ 8'(k));
            chk(got, 8'h3c);
            chk(lastRx, 8'ha5 ^ 8'(k));
            chk(nCmd, k + 1);
        end
        rdc(8'h00, 0);
        rdc(8'h0c, 32'ha);
    endtask
    task automatic t_discard();
        wr(8'h00, 32'h02);
        window(8'h5a);
        chk(nPush, 2);
        chk(misoOeN, 1);
        rdc(8'h00, 0);
    endtask
    task automatic t_status();
        wr(8'h10, 32'h09);
        window(8'h11);
        chk(got, 8'h3a);
        chk(nPop, 7);
        chk(lastRx, 8'h11);
    endtask
    task automatic t_stall();
        int i;
        wr(8'h10, 32'h03);
        wr(8'h00, 32'h20);
        rdc(8'h00, 32'h20);
        chk(masterGo, 0);
        txLevel <= 8'h03;
        for (i = 0; i < 10 && masterGo !== 1'b1; i++) @(posedge sys_clk);
        if (i == 10) begin
            n_errors++;
            tally_and_finish();
        end
        rdc(8'h00, 0);
    endtask
    // limit of one frame, then zero padding from five queued command bytes up to eight
    task automatic t_limit();
        wr(8'h10, 32'h0111);
        window(8'h77);
        chk(nPush, 3);
        chk(transferPause, 1);
        chk(nLim, 1);
        wr(8'h00, 32'h10);
        rdc(8'h00, 0);
        chk(transferPause, 0);
        txLevel <= 8'h05;
        wr(8'h10, 32'h0801);
        wr(8'h00, 32'h01);
        // bench stands in for the fifo: each zero push raises the level
        repeat (20) begin
            @(posedge sys_clk);
            if (zeroPush === 1'b1) txLevel <= txLevel + 8'h01;
        end
        chk(txLevel, 8'h08);
        rdc(8'h00, 32'h01);
    endtask
    initial begin
        #900000;
        n_errors++;
        tally_and_finish();
    end
    initial begin
        {rst_n, regWrEn, regRdEn, regAddr, regWrData} = '0;
        {txLevel, txHead, rxEmpty} = {16'h0, 1'b1};
        repeat (4) @(posedge sys_clk);
        rst_n <= 1'b1;
        t_regs();
        t_flush();
        t_early();
        t_discard();
        t_status();
        t_stall();
        t_limit();
        tally_and_finish();
    end
endmodule
